// >>> rtl/ir_modem_uart_wakeup.sv
// Serial channel zero with 9-bit wake-up filtering and an infrared modem on its pins.
// Assumes a classic Wishbone master on clk; the receive pin is asynchronous to clk.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module ir_modem_uart_wakeup
  import ir_modem_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_CYCLES_DEFAULT
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial pins.
  input wire logic serialRxPin,
  output logic serialTxPin,
  // Serial events.
  output logic serialRxIrq,
  output logic serialTxIrq
);
  logic [7:0] irControlReg_r;
  logic [7:0] serialModeCtrl0_r;
  logic [15:0] baudDiv_r;
  logic [15:0] baudCnt_r;
  logic baudTick_r;
  logic [13:0] regIndex;
  logic reqLive;
  logic commit;
  logic wrCommit;
  logic rxRead;
  logic txPulseWidthSelect;
  logic rxPulsePolaritySelect;
  logic irModulatorEnable;
  logic irDemodulatorEnable;
  logic irActive;
  logic wakeupFilterEnable;
  logic modeNine;
  logic rxEnable;
  logic [3:0] dataBits;
  txState_t txState_r;
  logic [3:0] txPhase_r;
  logic [3:0] txBitCnt_r;
  logic [8:0] txShift_r;
  logic txBit_r;
  logic txStart;
  logic rxMeta_r;
  logic rxSync_r;
  logic demodBit;
  logic irPulse;
  logic rxLine;
  rxState_t rxState_r;
  logic [3:0] rxPhase_r;
  logic [3:0] rxBitCnt_r;
  logic [8:0] rxShift_r;
  logic frameDone_r;
  logic [8:0] rxAligned;
  logic rxAccept;
  logic [7:0] rxData_r;
  logic rxNinthBit_r;
  logic rxFull_r;

  // Data bits per frame for the given mode field.
  function automatic logic [3:0] frameBits(input logic [1:0] mode, input logic irMode);
    if (irMode)
      frameBits = IR_DATA_BITS;
    else if (mode == FRAME_9BIT)
      frameBits = BITS_9;
    else if (mode == FRAME_7BIT)
      frameBits = BITS_7;
    else
      frameBits = IR_DATA_BITS;
  endfunction

  // Control fields.
  assign txPulseWidthSelect = irControlReg_r[IRC_TX_PULSE_WIDTH_SELECT];
  assign rxPulsePolaritySelect = irControlReg_r[IRC_RXPOL];
  assign irModulatorEnable = irControlReg_r[IRC_IR_MODULATOR_ENABLE];
  assign irDemodulatorEnable = irControlReg_r[IRC_IR_DEMODULATOR_ENABLE];
  assign irActive = irModulatorEnable || irDemodulatorEnable;
  assign wakeupFilterEnable = serialModeCtrl0_r[MODE_WAKE];
  assign rxEnable = serialModeCtrl0_r[MODE_RXE];
  assign modeNine = !irActive && (serialModeCtrl0_r[MODE_FRAME_LSB +: 2] == FRAME_9BIT);
  assign dataBits = frameBits(serialModeCtrl0_r[MODE_FRAME_LSB +: 2], irActive);

  // Bus decode; writes and read side effects take place on the acknowledged edge.
  assign regIndex = wb_adr_i[15:2];
  assign reqLive = wb_cyc_i && wb_stb_i;
  assign commit = reqLive && wb_ack_o;
  assign wrCommit = commit && wb_we_i;
  assign rxRead = commit && !wb_we_i && (regIndex == IDX_DATA_BUF);
  assign txStart = wrCommit && wb_sel_i[0] && (regIndex == IDX_DATA_BUF) && (txState_r == TX_IDLE);

  // Acknowledge one cycle after the request, drop it in the following cycle.
  always_ff @(posedge clk)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= reqLive && !wb_ack_o;
  end

  // Read data is captured with the request and stands beside the acknowledge.
  always_ff @(posedge clk)
  begin
    if (rst)
      wb_dat_o <= 32'h0000_0000;
    else if (reqLive && !wb_ack_o)
    begin
      case (regIndex)
        IDX_DATA_BUF: wb_dat_o <= {24'h00_0000, rxData_r};
        IDX_STATUS: wb_dat_o <= {24'h00_0000, rxNinthBit_r, 5'h00, (txState_r != TX_IDLE), rxFull_r};
        IDX_MODE: wb_dat_o <= {24'h00_0000, serialModeCtrl0_r};
        IDX_BAUD: wb_dat_o <= {16'h0000, baudDiv_r};
        IDX_IR_CTRL: wb_dat_o <= {24'h00_0000, irControlReg_r};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Infrared control register.
  always_ff @(posedge clk)
  begin
    if (rst)
      irControlReg_r <= IR_CTRL_RESET;
    else if (wrCommit && wb_sel_i[0] && regIndex == IDX_IR_CTRL)
      irControlReg_r <= wb_dat_i[7:0];
  end

  // Serial mode control; software clears the wake-up bit after a select match.
  always_ff @(posedge clk)
  begin
    if (rst)
      serialModeCtrl0_r <= MODE_RESET;
    else if (wrCommit && wb_sel_i[0] && regIndex == IDX_MODE)
      serialModeCtrl0_r <= wb_dat_i[7:0];
  end

  // Baud divisor, each byte lane written under its own select bit.
  always_ff @(posedge clk)
  begin
    if (rst)
      baudDiv_r <= BAUD_RESET;
    else if (wrCommit && regIndex == IDX_BAUD)
    begin
      if (wb_sel_i[0])
        baudDiv_r[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        baudDiv_r[15:8] <= wb_dat_i[15:8];
    end
  end

  // Sixteenth-bit tick every divisor plus one clocks.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      baudCnt_r <= 16'h0000;
      baudTick_r <= 1'b0;
    end
    else if (baudCnt_r >= baudDiv_r)
    begin
      baudCnt_r <= 16'h0000;
      baudTick_r <= 1'b1;
    end
    else
    begin
      baudCnt_r <= baudCnt_r + 16'h0001;
      baudTick_r <= 1'b0;
    end
  end

  // Transmitter: start bit, data LSB first with the ninth bit last, one stop bit.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      txState_r <= TX_IDLE;
      txPhase_r <= 4'h0;
      txBitCnt_r <= 4'h0;
      txShift_r <= 9'h000;
      txBit_r <= 1'b1;
    end
    else
    begin
      case (txState_r)
        TX_IDLE:
        begin
          if (txStart)
          begin
            txShift_r <= {serialModeCtrl0_r[MODE_TX9], wb_dat_i[7:0]};
            txBitCnt_r <= dataBits;
            txPhase_r <= 4'h0;
            txBit_r <= 1'b0;
            txState_r <= TX_START;
          end
        end
        TX_START, TX_DATA:
        begin
          if (baudTick_r)
          begin
            txPhase_r <= txPhase_r + 4'h1;
            if (txPhase_r == LAST_PHASE)
            begin
              if (txBitCnt_r == 4'h0)
              begin
                txBit_r <= 1'b1;
                txState_r <= TX_STOP;
              end
              else
              begin
                txBit_r <= txShift_r[0];
                txShift_r <= {1'b0, txShift_r[8:1]};
                txBitCnt_r <= txBitCnt_r - 4'h1;
                txState_r <= TX_DATA;
              end
            end
          end
        end
        TX_STOP:
        begin
          if (baudTick_r)
          begin
            txPhase_r <= txPhase_r + 4'h1;
            if (txPhase_r == LAST_PHASE)
              txState_r <= TX_IDLE;
          end
        end
        default: txState_r <= TX_IDLE;
      endcase
    end
  end

  // Transmit event just before the stop bit goes out.
  always_ff @(posedge clk)
  begin
    if (rst)
      serialTxIrq <= 1'b0;
    else
      serialTxIrq <= (txState_r == TX_DATA) && baudTick_r && (txPhase_r == LAST_PHASE) && (txBitCnt_r == 4'h0);
  end

  ir_pulse_modulator u_modulator (
    .clk(clk),
    .rst(rst),
    .enable(irModulatorEnable),
    .shortPulse(txPulseWidthSelect),
    .serialBit(txBit_r),
    .bitPhase(txPhase_r),
    .irPulse(irPulse)
  );

  // Pin driver: modulator output whenever either infrared enable is set, plain serial otherwise.
  always_ff @(posedge clk)
  begin
    if (rst)
      serialTxPin <= 1'b1;
    else
      serialTxPin <= irActive ? irPulse : txBit_r;
  end

  // Two-flop synchroniser for the receive pin.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
    end
    else
    begin
      rxMeta_r <= serialRxPin;
      rxSync_r <= rxMeta_r;
    end
  end

  ir_pulse_demodulator #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_demodulator (
    .clk(clk),
    .rst(rst),
    .enable(irDemodulatorEnable),
    .lowActive(rxPulsePolaritySelect),
    .widthCode(irControlReg_r[3:0]),
    .baudTick(baudTick_r),
    .rxSync(rxSync_r),
    .serialOut(demodBit)
  );

  assign rxLine = irActive ? demodBit : rxSync_r;

  // Receiver: checks the start bit at mid-bit, then samples each bit centre.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxState_r <= RX_IDLE;
      rxPhase_r <= 4'h0;
      rxBitCnt_r <= 4'h0;
      rxShift_r <= 9'h000;
      frameDone_r <= 1'b0;
    end
    else
    begin
      frameDone_r <= 1'b0;
      case (rxState_r)
        RX_IDLE:
        begin
          rxPhase_r <= 4'h0;
          if (rxEnable && !rxLine)
            rxState_r <= RX_START;
        end
        RX_START:
        begin
          if (baudTick_r)
          begin
            rxPhase_r <= rxPhase_r + 4'h1;
            if (rxPhase_r == MID_PHASE)
            begin
              rxPhase_r <= 4'h0;
              rxBitCnt_r <= dataBits;
              rxState_r <= rxLine ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA:
        begin
          if (baudTick_r)
          begin
            rxPhase_r <= rxPhase_r + 4'h1;
            if (rxPhase_r == LAST_PHASE)
            begin
              rxShift_r <= {rxLine, rxShift_r[8:1]};
              rxBitCnt_r <= rxBitCnt_r - 4'h1;
              if (rxBitCnt_r == 4'h1)
              begin
                frameDone_r <= modeNine;
                rxState_r <= RX_STOP;
              end
            end
          end
        end
        RX_STOP:
        begin
          if (baudTick_r)
          begin
            rxPhase_r <= rxPhase_r + 4'h1;
            if (rxPhase_r == LAST_PHASE)
            begin
              frameDone_r <= !modeNine;
              rxState_r <= RX_IDLE;
            end
          end
        end
        default: rxState_r <= RX_IDLE;
      endcase
    end
  end

  // Frame word right-aligned; in 9-bit mode bit 8 is the received ninth bit.
  assign rxAligned = rxShift_r >> (BITS_9 - dataBits);
  assign rxAccept = frameDone_r && (!(modeNine && wakeupFilterEnable) || rxAligned[8]);

  // Buffer, ninth bit and full flag; a new frame wins over a same-cycle read.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxData_r <= 8'h00;
      rxNinthBit_r <= 1'b0;
      rxFull_r <= 1'b0;
    end
    else if (rxAccept)
    begin
      rxData_r <= rxAligned[7:0];
      rxNinthBit_r <= modeNine && rxAligned[8];
      rxFull_r <= 1'b1;
    end
    else if (rxRead)
      rxFull_r <= 1'b0;
  end

  // Receive event for accepted frames only.
  always_ff @(posedge clk)
  begin
    if (rst)
      serialRxIrq <= 1'b0;
    else
      serialRxIrq <= rxAccept;
  end

  property p_wbAnswer;
    @(posedge clk) disable iff (rst) reqLive && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wbAnswer: assert property (p_wbAnswer) else $error("Bus answer not one cycle.");

  property p_filterDrop;
    @(posedge clk) disable iff (rst) frameDone_r && modeNine && wakeupFilterEnable && !rxShift_r[8] |=> !serialRxIrq;
  endproperty
  a_filterDrop: assert property (p_filterDrop) else $error("Filtered frame raised interrupt.");

  property p_filterPass;
    @(posedge clk) disable iff (rst)
      frameDone_r && modeNine && wakeupFilterEnable && rxShift_r[8] |=> serialRxIrq && rxNinthBit_r;
  endproperty
  a_filterPass: assert property (p_filterPass) else $error("Address frame not delivered.");

  property p_payloadKept;
    @(posedge clk) disable iff (rst) frameDone_r && !wakeupFilterEnable |=> serialRxIrq && rxFull_r;
  endproperty
  a_payloadKept: assert property (p_payloadKept) else $error("Unfiltered frame lost.");

  property p_irFormat;
    @(posedge clk) disable iff (rst) irActive |-> dataBits == IR_DATA_BITS && !modeNine;
  endproperty
  a_irFormat: assert property (p_irFormat) else $error("Infrared frame not eight bits.");

  property p_modOffLow;
    @(posedge clk) disable iff (rst) irActive && !irModulatorEnable ##1 irActive |=> !serialTxPin;
  endproperty
  a_modOffLow: assert property (p_modOffLow) else $error("Disabled modulator drove pin.");
endmodule

// >>> rtl/ir_pulse_demodulator.sv
// Infrared receive demodulator: qualifies pulses by width and polarity.
// Assumes rxSync is already synchronised and baudTick marks sixteenths of a bit.
`timescale 1ns/1ps
module ir_pulse_demodulator
  import ir_modem_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_CYCLES_DEFAULT
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control.
  input wire logic enable,
  input wire logic lowActive,
  input wire logic [3:0] widthCode,
  input wire logic baudTick,
  // Line in and serial out.
  input wire logic rxSync,
  output logic serialOut
);
  logic active;
  logic [15:0] minCycles;
  logic [15:0] widthCnt;
  logic [4:0] holdCnt;
  logic pulseMet;

  // Codes 0 and 15 are not legal; they are clamped to the nearest legal code.
  always_comb
  begin
    logic [3:0] code;
    code = widthCode;
    if (code < WIDTH_CODE_MIN)
      code = WIDTH_CODE_MIN;
    else if (code > WIDTH_CODE_MAX)
      code = WIDTH_CODE_MAX;
    minCycles = 16'(2 * (int'(code) + 1) * BASE_CYCLES + PULSE_PAD_CYCLES);
  end

  assign active = rxSync ^ lowActive;
  assign pulseMet = enable && active && (widthCnt == minCycles - 16'h0001);

  // Width counter runs while the active level lasts and stops at the minimum.
  always_ff @(posedge clk)
  begin
    if (rst || !enable || !active)
      widthCnt <= 16'h0000;
    else if (widthCnt != minCycles)
      widthCnt <= widthCnt + 16'h0001;
  end

  // A qualified pulse is stretched to one bit so the receiver can sample it.
  always_ff @(posedge clk)
  begin
    if (rst || !enable)
      holdCnt <= 5'h00;
    else if (pulseMet)
      holdCnt <= STRETCH_TICKS;
    else if (baudTick && holdCnt != 5'h00)
      holdCnt <= holdCnt - 5'h01;
  end

  // Zero while a qualified pulse is held, one otherwise.
  always_ff @(posedge clk)
  begin
    if (rst)
      serialOut <= 1'b1;
    else
      serialOut <= !(enable && (pulseMet || holdCnt != 5'h00));
  end

  property p_zeroNeedsWidth;
    @(posedge clk) disable iff (rst) $fell(serialOut) |-> $past(widthCnt) == $past(minCycles) - 16'h0001;
  endproperty
  a_zeroNeedsWidth: assert property (p_zeroNeedsWidth) else $error("Zero passed before minimum width.");

  property p_disabledIgnores;
    @(posedge clk) disable iff (rst) !enable |=> serialOut;
  endproperty
  a_disabledIgnores: assert property (p_disabledIgnores) else $error("Disabled demodulator passed data.");
endmodule

// >>> rtl/ir_pulse_modulator.sv
// Infrared transmit modulator: turns serial zeros into short high pulses.
// Assumes bitPhase counts sixteenths of the current serial bit from zero.
`timescale 1ns/1ps
module ir_pulse_modulator
  import ir_modem_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control and serial stream.
  input wire logic enable,
  input wire logic shortPulse,
  input wire logic serialBit,
  input wire logic [3:0] bitPhase,
  // Modulated output.
  output logic irPulse
);
  logic [3:0] phaseLimit;

  // Pulse length in sixteenths of a bit.
  assign phaseLimit = shortPulse ? PULSE_SHORT_PHASES : PULSE_LONG_PHASES;

  // High at the start of each zero bit, low for ones and while disabled.
  always_ff @(posedge clk)
  begin
    if (rst)
      irPulse <= 1'b0;
    else
      irPulse <= enable && !serialBit && (bitPhase < phaseLimit);
  end

  property p_pulseCause;
    @(posedge clk) disable iff (rst) irPulse |-> $past(enable) && !$past(serialBit);
  endproperty
  a_pulseCause: assert property (p_pulseCause) else $error("Pulse without enabled zero bit.");

  property p_pulseWidth;
    @(posedge clk) disable iff (rst)
      irPulse |-> $past(bitPhase) < ($past(shortPulse) ? PULSE_SHORT_PHASES : PULSE_LONG_PHASES);
  endproperty
  a_pulseWidth: assert property (p_pulseWidth) else $error("Pulse exceeds selected width.");
endmodule

// >>> shared/ir_modem_pkg.sv
// Constants, register map and state types for the IR modem with 9-bit wake-up.
// Assumes a 250 MHz system clock and a classic Wishbone slave with 32-bit data.
// Function
// - Wake-up enable turns on 9-bit frame filtering.
// - Filtering raises receive interrupt only when ninth bit is one.
// - Payload frames carry ninth bit clear; filtered slaves ignore.
// - Transmit zero becomes short high pulse on pin.
// - Transmit one keeps the pin low all bit.
// - Qualified active pulse yields zero, otherwise one.
// - Width select: 0 gives 3/16, 1 gives 1/16.
// - Minimum width 2x(N+1) base plus 100 ns; codes 1-14.
// - Demodulator disabled ignores incoming infrared data.
// - Modulator disabled ignores the serial output.
// - Infrared mode forces eight data bits, one stop.
// - Frame field 11 selects 9-bit mode, ninth bit stored.
package ir_modem_pkg;
  // Timing.
  localparam int CLK_PERIOD_NS = 4;
  localparam int PULSE_PAD_NS = 100;
  localparam int PULSE_PAD_CYCLES = (PULSE_PAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BASE_CYCLES_DEFAULT = 4;
  localparam logic [3:0] PULSE_LONG_PHASES = 4'h3;
  localparam logic [3:0] PULSE_SHORT_PHASES = 4'h1;
  localparam logic [3:0] MID_PHASE = 4'h7;
  localparam logic [3:0] LAST_PHASE = 4'hF;
  localparam logic [4:0] STRETCH_TICKS = 5'h10;
  localparam logic [3:0] WIDTH_CODE_MIN = 4'h1;
  localparam logic [3:0] WIDTH_CODE_MAX = 4'hE;
  // Register indices; byte address is four times the index.
  localparam logic [13:0] IDX_DATA_BUF = 14'h1200;
  localparam logic [13:0] IDX_STATUS = 14'h1201;
  localparam logic [13:0] IDX_MODE = 14'h1202;
  localparam logic [13:0] IDX_BAUD = 14'h1203;
  localparam logic [13:0] IDX_IR_CTRL = 14'h1207;
  // Infrared control fields; width code sits in bits 3:0.
  localparam int IRC_TX_PULSE_WIDTH_SELECT = 7;
  localparam int IRC_RXPOL = 6;
  localparam int IRC_IR_MODULATOR_ENABLE = 5;
  localparam int IRC_IR_DEMODULATOR_ENABLE = 4;
  // Serial mode control fields.
  localparam int MODE_TX9 = 7;
  localparam int MODE_RXE = 5;
  localparam int MODE_WAKE = 4;
  localparam int MODE_FRAME_LSB = 2;
  // Status fields.
  localparam int STAT_RX9 = 7;
  localparam int STAT_TXBUSY = 1;
  localparam int STAT_RXFULL = 0;
  // Frame modes and sizes.
  localparam logic [1:0] FRAME_7BIT = 2'h1;
  localparam logic [1:0] FRAME_9BIT = 2'h3;
  localparam logic [3:0] IR_DATA_BITS = 4'h8;
  localparam logic [3:0] BITS_7 = 4'h7;
  localparam logic [3:0] BITS_9 = 4'h9;
  // Reset values.
  localparam logic [7:0] IR_CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] BAUD_RESET = 16'h0001;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} txState_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rxState_t;
endpackage

// >>> testbench/serial_link_partner.sv
// Far-side model: another serial controller or an infrared transceiver on the receive pin.
// Assumes the bench clock; the line changes by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
module serial_link_partner
(
  // Clock.
  input wire logic clk,
  // Line toward the device.
  output logic rxLine
);
  logic idleLevel = 1'b1;

  // The line rests at its idle level until a frame is sent.
  initial rxLine = 1'b1;

  // Holds the line at one level for a number of clocks.
  task automatic hold_level(input logic level, input int clocks);
    @(posedge clk);
    rxLine <= level;
    repeat (clocks - 1) @(posedge clk);
  endtask

  // Changes the resting level, for a switch of pulse polarity.
  task automatic set_idle(input logic level);
    idleLevel = level;
    hold_level(level, 4);
  endtask

  // Sends start, data bits with the least significant first, then one stop bit.
  task automatic send_uart(input logic [8:0] value, input int nBits, input int bitClocks);
    hold_level(1'b0, bitClocks);
    for (int i = 0; i < nBits; i++)
    begin
      hold_level(value[i], bitClocks);
    end
    hold_level(1'b1, bitClocks);
  endtask

  // Sends an eight-bit infrared frame; each zero is one active pulse at the bit start.
  task automatic send_ir(input logic [7:0] value, input int bitClocks, input int pulseClocks);
    logic [9:0] bits;
    bits = {1'b1, value, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      if (bits[i] == 1'b0)
      begin
        hold_level(~idleLevel, pulseClocks);
        hold_level(idleLevel, bitClocks - pulseClocks);
      end
      else
        hold_level(idleLevel, bitClocks);
    end
  endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the infrared modem with 9-bit wake-up filtering.
// Assumes a one-cycle Wishbone answer and the partner model on the receive pin.
`timescale 1ns/1ps
module tb;
  import ir_modem_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] datW = 32'h0000_0000;
  logic [31:0] datR;
  logic [31:0] rd;
  logic ack;
  logic rxLine;
  logic txPin;
  logic rxIrq;
  logic txIrq;
  logic lastTx;
  int badCount = 0;
  int checkCount = 0;
  int rxIrqCount = 0;
  int txIrqCount = 0;
  int highCount;
  int edgeCount;

  // Clock at 250 MHz.
  initial
  begin
    forever #2 clk = ~clk;
  end

  ir_modem_uart_wakeup #(.BASE_CYCLES(1)) ir_modem_uart_wakeup_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datW), .wb_dat_o(datR),
    .wb_ack_o(ack), .serialRxPin(rxLine), .serialTxPin(txPin), .serialRxIrq(rxIrq), .serialTxIrq(txIrq));

  serial_link_partner serial_link_partner_i (.clk(clk), .rxLine(rxLine));

  // Counts receive and transmit events.
  always @(posedge clk)
  begin
    if (rxIrq === 1'b1)
      rxIrqCount++;
    if (txIrq === 1'b1)
      txIrqCount++;
  end

  task automatic check_val(input string name, input logic [31:0] expVal, input logic [31:0] seen);
    checkCount++;
    if (seen !== expVal)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", name, expVal, seen);
    end
  endtask

  // One classic cycle; the request is held until acknowledge is sampled high.
  task automatic wb_cycle(input logic [13:0] idx, input logic wr, input logic [31:0] wdata);
    int waitCount;
    waitCount = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {idx, 2'b00};
    datW <= wdata;
    do
    begin
      @(posedge clk);
      waitCount++;
    end
    while (ack !== 1'b1);
    rd = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // The slave answers one cycle after it takes the request.
    check_val("acknowledge wait", 32'h0000_0002, waitCount);
  endtask

  task automatic wr(input logic [13:0] idx, input logic [31:0] wdata);
    wb_cycle(idx, 1'b1, wdata);
  endtask

  task automatic rd_chk(input logic [13:0] idx, input logic [31:0] expVal, input string name);
    wb_cycle(idx, 1'b0, 32'h0000_0000);
    check_val(name, expVal, rd);
  endtask

  // Lets a frame finish, then compares the number of receive events.
  task automatic irq_delta(input int expN);
    repeat (120) @(posedge clk);
    check_val("receive events", expN, rxIrqCount);
    rxIrqCount = 0;
  endtask

  // Counts high clocks and pulses on the transmit pin over one frame.
  task automatic tx_pulses(input int expHigh, input int expEdges);
    highCount = 0;
    edgeCount = 0;
    txIrqCount = 0;
    lastTx = txPin;
    repeat (200)
    begin
      @(posedge clk);
      if (txPin === 1'b1)
        highCount++;
      if (txPin === 1'b1 && lastTx === 1'b0)
        edgeCount++;
      lastTx = txPin;
    end
    check_val("tx high clocks", expHigh, highCount);
    check_val("tx pulses", expEdges, edgeCount);
    check_val("tx events", 32'h0000_0001, txIrqCount);
  endtask

  task automatic completeRun;
    $display("Comparisons %0d, mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog for a hung run.
  initial
  begin
    repeat (30000) @(posedge clk);
    badCount++;
    completeRun;
  end

  // Main sequence.
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(IDX_IR_CTRL, IR_CTRL_RESET, "ir control reset");
    rd_chk(IDX_MODE, MODE_RESET, "mode reset");
    rd_chk(IDX_BAUD, BAUD_RESET, "baud reset");
    wr(14'h1205, 8'hFF);
    rd_chk(14'h1205, 8'h00, "unmapped");
    wr(IDX_BAUD, 8'h00);
    wr(IDX_MODE, 8'h3C);
    serial_link_partner_i.send_uart(9'h05A, 9, 16);
    irq_delta(0);
    serial_link_partner_i.send_uart(9'h1A5, 9, 16);
    irq_delta(1);
    rd_chk(IDX_STATUS, 8'h81, "status address");
    rd_chk(IDX_DATA_BUF, 8'hA5, "address data");
    wr(IDX_MODE, 8'h2D);
    rd_chk(IDX_MODE, 8'h2D, "mode stored");
    serial_link_partner_i.send_uart(9'h03C, 9, 16);
    irq_delta(1);
    rd_chk(IDX_STATUS, 8'h01, "status payload");
    rd_chk(IDX_DATA_BUF, 8'h3C, "payload data");
    // Infrared transmit; five zeros in an eight-bit frame.
    wr(IDX_IR_CTRL, 8'h20);
    serial_link_partner_i.set_idle(1'b0);
    wr(IDX_DATA_BUF, 8'h55);
    tx_pulses(15, 5);
    wr(IDX_IR_CTRL, 8'hA0);
    wr(IDX_DATA_BUF, 8'h55);
    tx_pulses(5, 5);
    wr(IDX_IR_CTRL, 8'h17);
    wr(IDX_DATA_BUF, 8'h55);
    tx_pulses(0, 0);
    // Infrared receive at 64 clocks per bit.
    wr(IDX_BAUD, 8'h03);
    wr(IDX_IR_CTRL, 8'h07);
    wr(IDX_IR_CTRL, 8'h37);
    serial_link_partner_i.send_ir(8'h96, 64, 48);
    irq_delta(1);
    rd_chk(IDX_DATA_BUF, 8'h96, "ir data");
    serial_link_partner_i.send_ir(8'h96, 64, 30);
    irq_delta(0);
    wr(IDX_IR_CTRL, 8'h3E);
    serial_link_partner_i.send_ir(8'h96, 64, 48);
    irq_delta(0);
    wr(IDX_IR_CTRL, 8'h67);
    serial_link_partner_i.set_idle(1'b1);
    serial_link_partner_i.send_ir(8'h69, 64, 48);
    irq_delta(0);
    wr(IDX_IR_CTRL, 8'h77);
    serial_link_partner_i.send_ir(8'h69, 64, 48);
    irq_delta(1);
    rd_chk(IDX_DATA_BUF, 8'h69, "low pulse data");
    completeRun;
  end
endmodule
